/* rtl/rot_carry_pkg.sv */
// Package of opcode fields and reset values for the rotate-through-carry unit
package rot_carry_pkg;
   localparam int WORD_W = 8;
   localparam int ADDR_W = 7;
   localparam int INSN_W = 14;
   localparam int OPC_LSB = 8;
   localparam int DEST_BIT = 7;
   localparam logic [5:0] OPC_ROT_LEFT = 6'h0d;
   localparam logic [5:0] OPC_ROT_RIGHT = 6'h0c;
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic CARRY_RESET = 1'b0;
   localparam logic [7:0] WDATA_RESET = 8'h00;
   localparam logic [6:0] WB_ADDR_RESET = 7'h00;
   localparam logic PULSE_IDLE = 1'h0;
   localparam logic DEST_ACC = 1'b0;
   localparam logic DEST_FILE = 1'b1;

   // Rotate operation kinds
   typedef enum logic [1:0]
   {
      ROT_NONE = 2'b00,
      ROT_LEFT = 2'b01,
      ROT_RIGHT = 2'b10
   } rot_kind_t;
endpackage : rot_carry_pkg

/* rtl/rot_result_if.sv */
// Interface carrying decoded operation and rotated result between modules
interface rot_result_if;
   import rot_carry_pkg::*;
   rot_kind_t kind; // Decoded rotate kind
   logic [7:0] operand; // Source operand
   logic carry_in; // Current carry
   logic [7:0] result; // Rotated value
   logic carry_out; // New carry

   modport core
   (
      output kind,
      output operand,
      output carry_in,
      input result,
      input carry_out
   );
   modport shifter
   (
      input kind,
      input operand,
      input carry_in,
      output result,
      output carry_out
   );
endinterface : rot_result_if

/* rtl/rot_shifter.sv */
// Combinational one-place rotate through carry
module rot_shifter
   import rot_carry_pkg::*;
(
   rot_result_if.shifter port
);
   ////////////////////////////////////////////////////////////////////////////
   // Rotate selected by operation kind
   always_comb
   begin
      port.result = port.operand;
      port.carry_out = port.carry_in;
      case (port.kind)
         ROT_LEFT:
         begin
            // Old carry into bit 0, bit 7 out
            port.result = {port.operand[6:0], port.carry_in};
            port.carry_out = port.operand[7];
         end
         ROT_RIGHT:
         begin
            // Old carry into bit 7, bit 0 out
            port.result = {port.carry_in, port.operand[7:1]};
            port.carry_out = port.operand[0];
         end
         default:
         begin
            // No rotate: pass through
            port.result = port.operand;
         end
      endcase
   end
endmodule : rot_shifter

/* rtl/rotate_through_carry_unit.sv */
// Rotate-through-carry datapath slice with accumulator and carry flag
// Overview of operation
// - Left rotate: carry in bit0, bit7 out
// - Right rotate: carry in bit7, bit0 out
// - Left result to accumulator or file by destination
// - Right result to selected target, other unchanged
// - Seven-bit file address, one-bit destination accepted
module rotate_through_carry_unit
   import rot_carry_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic insn_valid,
   input wire logic [13:0] insn,
   input wire logic [7:0] file_rdata,
   output logic [6:0] file_addr,
   output logic file_we,
   output logic [7:0] file_wdata,
   output logic [7:0] acc,
   output logic carry,
   output logic busy_done
);
   ////////////////////////////////////////////////////////////////////////////
   // Decode
   rot_result_if rot (); // Carrier between this module and the shifter
   rot_kind_t kind; // Decoded kind, none when idle or not a rotate
   logic dest; // Destination bit of the word
   logic [ADDR_W-1:0] reg_sel; // File register named by the word

   // Opcode field of an instruction word
   function automatic logic [5:0] opcode_of(input logic [INSN_W-1:0] word);
      return word[INSN_W-1:OPC_LSB];
   endfunction : opcode_of

   // Rotate kind named by an instruction word; any other opcode is none
   function automatic rot_kind_t decode_kind(input logic [INSN_W-1:0] word);
      rot_kind_t k;
      k = ROT_NONE;
      if (opcode_of(word) == OPC_ROT_LEFT)
      begin
         // Rotate toward the most significant end
         k = ROT_LEFT;
      end
      else if (opcode_of(word) == OPC_ROT_RIGHT)
      begin
         // Rotate toward the least significant end
         k = ROT_RIGHT;
      end
      return k;
   endfunction : decode_kind

   // Decode one word per cycle; an idle cycle or a foreign opcode does nothing
   always_comb
   begin
      kind = ROT_NONE;
      if (insn_valid)
      begin
         // Word offered this cycle
         kind = decode_kind(insn);
      end
      dest = insn[DEST_BIT];
      reg_sel = insn[ADDR_W-1:0];
   end

   // Address goes straight out so the operand comes back in the same cycle
   assign file_addr = reg_sel;

   ////////////////////////////////////////////////////////////////////////////
   // Write-back bypass
   logic [ADDR_W-1:0] wb_addr; // Register that the write on the port belongs to
   logic [ADDR_W-1:0] next_wb_addr; // Address remembered for the next cycle
   logic hazard; // Write on the port targets the register read now
   logic [WORD_W-1:0] operand; // Source value handed to the shifter

   // The write port is registered, so a result reaches the file one cycle
   // after its rotate. A rotate in that cycle on the same register would
   // read stale contents; the pending write data is forwarded instead.
   always_comb
   begin
      next_wb_addr = reg_sel;
      hazard = file_we & (wb_addr == reg_sel);
      operand = file_rdata;
      if (hazard)
      begin
         // Newest value is still on the write port
         operand = file_wdata;
      end
   end

   // Register the address that a write issued this cycle belongs to
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         // No write pending after reset
         wb_addr <= WB_ADDR_RESET;
      end
      else
      begin
         wb_addr <= next_wb_addr;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Shifter
   assign rot.kind = kind; // Nothing rotates unless a rotate was decoded
   assign rot.operand = operand; // Bypassed source register
   assign rot.carry_in = carry; // Carry flag as it stands this cycle

   // One-place rotate through carry
   rot_shifter u_shift
   (
      .port(rot.shifter)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Carry flag
   logic next_carry; // Carry after this cycle

   // A rotate replaces the carry with the bit pushed out; nothing else touches it
   always_comb
   begin
      next_carry = carry;
      if (kind != ROT_NONE)
      begin
         // Bit shifted out of the operand
         next_carry = rot.carry_out;
      end
   end

   // Carry register
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         // Carry clear after reset
         carry <= CARRY_RESET;
      end
      else
      begin
         carry <= next_carry;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Accumulator
   logic [WORD_W-1:0] next_acc; // Accumulator after this cycle

   // Loaded only by a rotate whose destination bit is clear
   always_comb
   begin
      next_acc = acc;
      if ((kind != ROT_NONE) && (dest == DEST_ACC))
      begin
         // Result to the accumulator, file register untouched
         next_acc = rot.result;
      end
   end

   // Accumulator register
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         // Accumulator clear after reset
         acc <= ACC_RESET;
      end
      else
      begin
         acc <= next_acc;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // File write port
   logic next_file_we; // Write strobe for the next cycle
   logic [WORD_W-1:0] next_file_wdata; // Write data for the next cycle

   // A rotate with the destination bit set writes back to its source; the data
   // holds between writes so the port never shows a stray value
   always_comb
   begin
      next_file_we = PULSE_IDLE;
      next_file_wdata = file_wdata;
      if ((kind != ROT_NONE) && (dest == DEST_FILE))
      begin
         // Result back to the addressed register, accumulator untouched
         next_file_we = 1'h1;
         next_file_wdata = rot.result;
      end
   end

   // Write port registers; the strobe lasts one cycle
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         // No write during or right after reset
         file_we <= PULSE_IDLE;
         file_wdata <= WDATA_RESET;
      end
      else
      begin
         file_we <= next_file_we;
         file_wdata <= next_file_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Completion pulse
   logic next_done; // Pulse for the next cycle

   // One pulse for every rotate carried out
   always_comb
   begin
      next_done = PULSE_IDLE;
      if (kind != ROT_NONE)
      begin
         // Rotate finishes in this single cycle
         next_done = 1'h1;
      end
   end

   // Completion register
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         // Quiet after reset
         busy_done <= PULSE_IDLE;
      end
      else
      begin
         busy_done <= next_done;
      end
   end
endmodule : rotate_through_carry_unit

/* tb/rot_unit_properties.sv */
// Port assertions for the rotate unit
module rot_unit_properties
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic insn_valid,
   input wire logic [13:0] insn,
   input wire logic [7:0] file_rdata,
   input wire logic [6:0] file_addr,
   input wire logic file_we,
   input wire logic [7:0] file_wdata,
   input wire logic [7:0] acc,
   input wire logic carry,
   input wire logic busy_done
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   logic [6:0] last_sel; // Register named by the previous word
   // Remember the previous register; its write may still be on the port
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         last_sel <= 7'h00;
      else
         last_sel <= insn[6:0];
   end
   wire r = insn_valid & (insn[13:9] == 5'h06); // Rotate executes
   wire hit = file_we & (last_sel == insn[6:0]); // Newest value not yet in the file
   wire [7:0] src = hit ? file_wdata : file_rdata; // Current register value
   wire [7:0] lv = {src[6:0], carry}; // Left result
   wire [7:0] rv = {carry, src[7:1]}; // Right result
   property p_l;
      r & insn[8] & !insn[7] |=> acc == $past(lv);
   endproperty
   a_l: assert property (p_l) else $error("left acc");
   property p_r;
      r & !insn[8] & !insn[7] |=> acc == $past(rv);
   endproperty
   a_r: assert property (p_r) else $error("right acc");
   property p_c;
      r |=> carry == $past(insn[8] ? src[7] : src[0]);
   endproperty
   a_c: assert property (p_c) else $error("carry");
   property p_f;
      r & insn[7] |=> file_we & file_wdata == $past(insn[8] ? lv : rv) & $stable(acc);
   endproperty
   a_f: assert property (p_f) else $error("file");
   property p_n;
      !r |=> !busy_done & !file_we & $stable(carry) & $stable(acc);
   endproperty
   a_n: assert property (p_n) else $error("idle");
   property p_b;
      r |=> busy_done;
   endproperty
   a_b: assert property (p_b) else $error("done");
   property p_a;
      file_addr == insn[6:0];
   endproperty
   a_a: assert property (p_a) else $error("address");
   c_l: cover property (r & insn[8]);
   c_r: cover property (r & !insn[8]);
   c_f: cover property (r & insn[7]);
   c_h: cover property (r & hit);
endmodule : rot_unit_properties
bind rotate_through_carry_unit rot_unit_properties chk
(
   .ref_clk(ref_clk),
   .rst(rst),
   .insn_valid(insn_valid),
   .insn(insn),
   .file_rdata(file_rdata),
   .file_addr(file_addr),
   .file_we(file_we),
   .file_wdata(file_wdata),
   .acc(acc),
   .carry(carry),
   .busy_done(busy_done)
);

/* tb/rot_file_model.sv */
// File register array beside the rotate unit
module rot_file_model
(
   input wire logic ref_clk,
   input wire logic [6:0] file_addr,
   input wire logic file_we,
   input wire logic [7:0] file_wdata,
   output logic [7:0] file_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [128]; // Registers 0 to 127
   logic [6:0] wr_addr; // Address of the executing cycle
   assign file_rdata = mem[file_addr];
   // Write lands one cycle late at the latched address
   always @(posedge ref_clk)
   begin
      if (file_we)
         mem[wr_addr] <= file_wdata;
      wr_addr <= file_addr;
   end
endmodule : rot_file_model

/* tb/tb_top.sv */
// Bench for the rotate unit
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   `define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
      $display("MISMATCH %0t %h %h", $time, a, b); end end
   logic ref_clk = 1'b0, rst = 1'b1, insn_valid = 1'b0;
   logic [13:0] insn = 14'h0000;
   wire [7:0] file_rdata, file_wdata, acc;
   wire [6:0] file_addr;
   wire file_we, carry, busy_done;
   int err_total = 0, n_checks = 0, cyc = 0;
   rotate_through_carry_unit uut
   (
      .ref_clk(ref_clk),
      .rst(rst),
      .insn_valid(insn_valid),
      .insn(insn),
      .file_rdata(file_rdata),
      .file_addr(file_addr),
      .file_we(file_we),
      .file_wdata(file_wdata),
      .acc(acc),
      .carry(carry),
      .busy_done(busy_done)
   );
   rot_file_model fm
   (
      .ref_clk(ref_clk),
      .file_addr(file_addr),
      .file_we(file_we),
      .file_wdata(file_wdata),
      .file_rdata(file_rdata)
   );
   initial
      forever #50 ref_clk = ~ref_clk;
   task automatic exec(input logic [13:0] w);
      @(posedge ref_clk);
      insn_valid <= 1'b1;
      insn <= w;
      @(posedge ref_clk);
      insn_valid <= 1'b0;
      #1;
   endtask : exec
   task automatic t_acc;
      fm.mem[7'h05] = 8'he6;
      exec(14'h0d05);
      `CHK(acc, 8'hcc)
      `CHK({carry, busy_done, file_we}, 3'h6)
      $display("t_acc done");
   endtask : t_acc
   task automatic t_file;
      fm.mem[7'h7f] = 8'he7;
      exec(14'h0cff);
      `CHK({carry, file_we, file_wdata}, 10'h3f3)
      @(posedge ref_clk);
      #1;
      `CHK({fm.mem[7'h7f], acc}, 16'hf3cc)
      $display("t_file done");
   endtask : t_file
   task automatic t_skip;
      exec(14'h0e7f);
      `CHK({acc, carry, busy_done, file_we}, 11'h664)
      // A rotate word offered without its valid strobe is ignored
      @(posedge ref_clk);
      insn <= 14'h0d05;
      repeat (2) @(posedge ref_clk);
      #1;
      `CHK({acc, carry, busy_done, file_we}, 11'h664)
      $display("t_skip done");
   endtask : t_skip
   // Back to back rotates on one register, then a right rotate to the accumulator
   task automatic t_chain;
      fm.mem[7'h12] = 8'h81;
      @(posedge ref_clk);
      insn_valid <= 1'h1;
      insn <= 14'h0d92;
      @(posedge ref_clk);
      #1;
      `CHK({acc, carry, file_we, file_wdata}, 18'h33303)
      @(posedge ref_clk);
      insn <= 14'h0c12;
      #1;
      `CHK({acc, carry, file_we, file_wdata}, 18'h33107)
      @(posedge ref_clk);
      insn_valid <= 1'h0;
      #1;
      `CHK({acc, carry, file_we, file_wdata}, 18'h00e07)
      `CHK({busy_done, fm.mem[7'h12]}, 9'h107)
      $display("t_chain done");
   endtask : t_chain
   // Reset in mid run clears the state; the first rotate after it works
   task automatic t_reset;
      @(posedge ref_clk);
      rst <= 1'h1;
      @(posedge ref_clk);
      #1;
      `CHK({acc, carry, busy_done, file_we, file_wdata}, 19'h00000)
      @(posedge ref_clk);
      rst <= 1'h0;
      exec(14'h0d05);
      `CHK({acc, carry, busy_done, file_we}, 11'h666)
      $display("t_reset done");
   endtask : t_reset
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : complete_run
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 200)
      begin
         err_total++;
         complete_run();
      end
   end
   initial
   begin
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      t_acc();
      t_file();
      t_skip();
      t_chain();
      t_reset();
      complete_run();
   end
endmodule : tb_top
